// *** verilog/ebl_pkg.sv ***
// Shared types and constants of the emulator break and link control
package ebl_pkg;

    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned SPACE_SIZE      = 4096;
    localparam int unsigned CNT_W           = 16;
    localparam int unsigned CFG_W           = 4;

    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned EP_RST_HOLD_NS  = 500;
    localparam logic [15:0] EP_RST_CYCLES   =
        16'((EP_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam logic [7:0]  LINK_RST        = 8'h00;
    localparam logic [3:0]  PORT_CFG_RST    = 4'h0;

    typedef enum logic [2:0] {
        run_breaks_disabled,
        run_breaks_enabled,
        single_step_mode,
        auto_step_mode,
        auto_break_mode
    } ebl_mode_e;

    typedef enum logic [1:0] {
        map_none,
        map_program,
        map_ext_data
    } ebl_map_e;

    typedef enum {
        st_halted,
        st_run,
        st_one_fetch,
        st_step,
        st_step_idle,
        st_break_pause,
        st_reset_hold
    } ebl_state_e;

    typedef struct packed {
        logic              prog_fetch;
        logic [11:0]       prog_addr;
        logic              data_rd;
        logic              data_wr;
        logic [11:0]       data_addr;
        logic [7:0]        wdata;
    } ebl_ep_bus_s;

    typedef struct packed {
        logic              set;
        logic              clr;
        logic              space_data;
        logic [11:0]       addr;
    } ebl_bp_cmd_s;

endpackage

// *** verilog/ebl_sync3.sv ***
// Three-stage input synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ps
module ebl_sync3 #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  logic         clk_in,
    input  logic         nrst_in,
    // Raw and filtered levels
    input  logic [W-1:0] async_in,
    output logic [W-1:0] level_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } ebl_sync_s;

    ebl_sync_s q_ff;
    ebl_sync_s nxt_q;

    always_comb begin
        nxt_q     = q_ff;
        nxt_q.s1  = async_in;
        nxt_q.s2  = q_ff.s1;
        nxt_q.s3  = q_ff.s2;
        for (int i = 0; i < W; i++) begin
            if (q_ff.s2[i] == q_ff.s3[i]) begin
                nxt_q.lvl[i] = q_ff.s3[i];
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign level_out = q_ff.lvl;

endmodule

// *** verilog/ebl_break_link.sv ***
// Break, breakpoint and link latch control between supervisor and emulation processor
`timescale 1ns/1ps
module ebl_break_link (
    // Clock and reset
    input  logic                clk_in,
    input  logic                nrst_in,
    // Supervisor link access
    input  logic                sup_link_wr_in,
    input  logic [7:0]          sup_link_wdata_in,
    output logic [7:0]          sup_link_rdata_out,
    output logic                ep_link_wrote_out,
    input  ebl_pkg::ebl_map_e   link_map_in,
    // Supervisor control
    input  ebl_pkg::ebl_mode_e  mode_in,
    input  logic                release_in,
    input  logic                fetch_one_in,
    input  logic                reset_run_in,
    input  logic                system_reset_command_in,
    input  logic [15:0]         pause_cycles_in,
    input  logic [15:0]         idle_cycles_in,
    input  ebl_pkg::ebl_bp_cmd_s bp_cmd_in,
    // Supervisor status
    output logic                halted_out,
    output logic                break_out,
    output logic                sup_reset_out,
    // Emulation processor bus
    input  ebl_pkg::ebl_ep_bus_s ep_bus_in,
    output logic [7:0]          ep_rdata_out,
    output logic                link_oe_out,
    output logic                prog_ram_dis_out,
    output logic                data_ram_dis_out,
    output logic                ep_hold_out,
    output logic                ep_reset_out,
    // Operator and user pins
    input  logic                key_press_in,
    input  logic [3:0]          port_cfg_in,
    output logic [3:0]          port_cfg_out,
    output logic                bp_pulse_out
);

    typedef struct packed {
        ebl_pkg::ebl_state_e st;
        logic [7:0]          link;
        logic [4095:0]       program_break_flags;
        logic [4095:0]       data_break_flags;
        logic [15:0]         cnt;
        logic                pulse;
        logic                ep_wr;
        logic                brk;
        logic                sup_rst;
        logic                key_d;
        logic [3:0]          port_cfg;
    } ebl_core_s;

    ebl_core_s q_ff;
    ebl_core_s nxt_q;

    logic [4:0] sync_lvl;
    logic       key_lvl;
    logic [3:0] cfg_lvl;
    logic       hit_prog;
    logic       hit_data;
    logic       hit;
    logic       key_rise;
    logic       ep_link_load;
    logic       bp_wr;

    ebl_sync3 #(
        .W (5)
    ) u_pin_sync (
        .clk_in    (clk_in),
        .nrst_in   (nrst_in),
        .async_in  ({key_press_in, port_cfg_in}),
        .level_out (sync_lvl)
    );

    assign key_lvl = sync_lvl[4];
    assign cfg_lvl = sync_lvl[3:0];

    // Flag lookup on every access
    assign hit_prog = ep_bus_in.prog_fetch
                      && q_ff.program_break_flags[ep_bus_in.prog_addr];
    assign hit_data = (ep_bus_in.data_rd || ep_bus_in.data_wr)
                      && q_ff.data_break_flags[ep_bus_in.data_addr];
    assign hit      = hit_prog || hit_data;
    assign key_rise = key_lvl && !q_ff.key_d;
    // Emulation processor write into the mapped latch
    assign ep_link_load = (link_map_in == ebl_pkg::map_ext_data) && ep_bus_in.data_wr;
    assign bp_wr        = bp_cmd_in.set || bp_cmd_in.clr;

    always_comb begin
        nxt_q         = q_ff;
        nxt_q.pulse   = 1'b0;
        nxt_q.ep_wr   = 1'b0;
        nxt_q.sup_rst = 1'b0;
        nxt_q.key_d   = key_lvl;

        // Link latch loads
        if (sup_link_wr_in) begin
            nxt_q.link = sup_link_wdata_in;
        end
        if (ep_link_load) begin
            nxt_q.link  = ep_bus_in.wdata;
            nxt_q.ep_wr = 1'b1;
        end

        // Per-address flag update, set wins over clear
        if (bp_wr) begin
            if (bp_cmd_in.space_data) begin
                nxt_q.data_break_flags[bp_cmd_in.addr] = bp_cmd_in.set;
            end else begin
                nxt_q.program_break_flags[bp_cmd_in.addr] = bp_cmd_in.set;
            end
        end

        unique case (q_ff.st)
            ebl_pkg::st_halted: begin
                // Port directions taken only while stopped
                nxt_q.port_cfg = cfg_lvl;
                if (fetch_one_in) begin
                    nxt_q.st = ebl_pkg::st_one_fetch;
                end else if (release_in) begin
                    nxt_q.brk = 1'b0;
                    // Step modes stop after each fetch
                    unique case (mode_in)
                        ebl_pkg::single_step_mode,
                        ebl_pkg::auto_step_mode: begin
                            nxt_q.st = ebl_pkg::st_step;
                        end
                        ebl_pkg::run_breaks_disabled,
                        ebl_pkg::run_breaks_enabled,
                        ebl_pkg::auto_break_mode: begin
                            nxt_q.st = ebl_pkg::st_run;
                        end
                        default: begin
                            nxt_q.st = ebl_pkg::st_halted;
                        end
                    endcase
                end
            end
            ebl_pkg::st_one_fetch: begin
                // Call or return-restore fetch, then stop
                if (ep_bus_in.prog_fetch) begin
                    nxt_q.st = ebl_pkg::st_halted;
                end
            end
            ebl_pkg::st_run: begin
                // Key press wins over a match
                if (key_rise) begin
                    nxt_q.st  = ebl_pkg::st_halted;
                    nxt_q.brk = 1'b1;
                end else if (hit) begin
                    unique case (mode_in)
                        ebl_pkg::run_breaks_disabled: begin
                            nxt_q.pulse = 1'b1;
                        end
                        ebl_pkg::auto_break_mode: begin
                            nxt_q.st  = ebl_pkg::st_break_pause;
                            nxt_q.cnt = pause_cycles_in;
                        end
                        ebl_pkg::run_breaks_enabled,
                        ebl_pkg::single_step_mode,
                        ebl_pkg::auto_step_mode: begin
                            nxt_q.st  = ebl_pkg::st_halted;
                            nxt_q.brk = 1'b1;
                        end
                        default: begin
                            nxt_q.st  = ebl_pkg::st_halted;
                            nxt_q.brk = 1'b1;
                        end
                    endcase
                end
            end
            ebl_pkg::st_break_pause: begin
                // Pause counts down, key stops it
                if (key_rise) begin
                    nxt_q.st  = ebl_pkg::st_halted;
                    nxt_q.brk = 1'b1;
                end else if (q_ff.cnt == 16'h0000) begin
                    nxt_q.st = ebl_pkg::st_run;
                end else begin
                    nxt_q.cnt = q_ff.cnt - 16'h0001;
                end
            end
            ebl_pkg::st_step: begin
                // One instruction fetch per step
                if (key_rise) begin
                    nxt_q.st  = ebl_pkg::st_halted;
                    nxt_q.brk = 1'b1;
                end else if (ep_bus_in.prog_fetch) begin
                    if (mode_in == ebl_pkg::auto_step_mode) begin
                        nxt_q.st  = ebl_pkg::st_step_idle;
                        nxt_q.cnt = idle_cycles_in;
                    end else begin
                        nxt_q.st = ebl_pkg::st_halted;
                    end
                end
            end
            ebl_pkg::st_step_idle: begin
                // Idle between steps; key or mode change stops
                if (key_rise) begin
                    nxt_q.st  = ebl_pkg::st_halted;
                    nxt_q.brk = 1'b1;
                end else if (mode_in != ebl_pkg::auto_step_mode) begin
                    nxt_q.st = ebl_pkg::st_halted;
                end else if (q_ff.cnt == 16'h0000) begin
                    nxt_q.st = ebl_pkg::st_step;
                end else begin
                    nxt_q.cnt = q_ff.cnt - 16'h0001;
                end
            end
            ebl_pkg::st_reset_hold: begin
                // Hold in reset, then run from zero
                if (q_ff.cnt == 16'h0000) begin
                    nxt_q.st = ebl_pkg::st_run;
                end else begin
                    nxt_q.cnt = q_ff.cnt - 16'h0001;
                end
            end
            default: begin
                nxt_q.st = ebl_pkg::st_halted;
            end
        endcase

        // Reset-run command
        if (reset_run_in) begin
            nxt_q.st  = ebl_pkg::st_reset_hold;
            nxt_q.cnt = ebl_pkg::EP_RST_CYCLES - 16'h0001;
            nxt_q.brk = 1'b0;
            nxt_q.pulse = 1'b0;
        end

        // System reset overrides everything
        if (system_reset_command_in) begin
            nxt_q.program_break_flags = '0;
            nxt_q.data_break_flags    = '0;
            nxt_q.link                = ebl_pkg::LINK_RST;
            nxt_q.brk                 = 1'b0;
            nxt_q.pulse               = 1'b0;
            nxt_q.ep_wr               = 1'b0;
            nxt_q.sup_rst             = 1'b1;
            nxt_q.st                  = ebl_pkg::st_reset_hold;
            nxt_q.cnt                 = ebl_pkg::EP_RST_CYCLES - 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q_ff          <= '0;
            q_ff.st       <= ebl_pkg::st_halted;
            q_ff.link     <= ebl_pkg::LINK_RST;
            q_ff.port_cfg <= ebl_pkg::PORT_CFG_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Latch drives the bus on any address of the mapped space
    always_comb begin
        link_oe_out = 1'b0;
        unique case (link_map_in)
            ebl_pkg::map_program: begin
                link_oe_out = ep_bus_in.prog_fetch;
            end
            ebl_pkg::map_ext_data: begin
                link_oe_out = ep_bus_in.data_rd;
            end
            default: begin
                link_oe_out = 1'b0;
            end
        endcase
    end

    // Mapped space disables its RAM
    assign prog_ram_dis_out   = (link_map_in == ebl_pkg::map_program);
    assign data_ram_dis_out   = (link_map_in == ebl_pkg::map_ext_data);

    // Latch contents to both sides
    assign ep_rdata_out       = q_ff.link;
    assign sup_link_rdata_out = q_ff.link;

    // Registered status and pulses
    assign ep_link_wrote_out  = q_ff.ep_wr;
    assign bp_pulse_out       = q_ff.pulse;
    assign break_out          = q_ff.brk;
    assign sup_reset_out      = q_ff.sup_rst;
    assign port_cfg_out       = q_ff.port_cfg;

    // Held in halt, pause and step idle; reset uses its own pin
    always_comb begin
        halted_out   = 1'b0;
        ep_hold_out  = 1'b0;
        ep_reset_out = 1'b0;
        unique case (q_ff.st)
            ebl_pkg::st_halted: begin
                halted_out  = 1'b1;
                ep_hold_out = 1'b1;
            end
            ebl_pkg::st_break_pause,
            ebl_pkg::st_step_idle: begin
                ep_hold_out = 1'b1;
            end
            ebl_pkg::st_reset_hold: begin
                ep_reset_out = 1'b1;
            end
            ebl_pkg::st_run,
            ebl_pkg::st_one_fetch,
            ebl_pkg::st_step: begin
                ep_hold_out = 1'b0;
            end
            default: begin
                ep_hold_out = 1'b1;
            end
        endcase
    end

endmodule

// *** testbench/ebl_break_link_assertions.sv ***
// Port checks for the break and link control
`timescale 1ns/1ps
module ebl_break_link_assertions (
    // Clock, reset and watched ports
    input logic                 clk_in,
    input logic                 nrst_in,
    input logic                 sup_link_wr_in,
    input logic [7:0]           sup_link_wdata_in,
    input logic [7:0]           sup_link_rdata_out,
    input logic                 ep_link_wrote_out,
    input ebl_pkg::ebl_map_e    link_map_in,
    input logic                 fetch_one_in,
    input logic                 reset_run_in,
    input logic                 system_reset_command_in,
    input ebl_pkg::ebl_ep_bus_s ep_bus_in,
    input logic                 halted_out,
    input logic                 break_out,
    input logic                 sup_reset_out,
    input logic                 ep_hold_out,
    input logic                 ep_reset_out,
    input logic [3:0]           port_cfg_out,
    input logic                 bp_pulse_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic ep_wr;
    logic any_acc;
    logic sr;
    assign ep_wr = ep_bus_in.data_wr && link_map_in == ebl_pkg::map_ext_data;
    assign any_acc = ep_bus_in.prog_fetch || ep_bus_in.data_rd || ep_bus_in.data_wr;
    assign sr = system_reset_command_in;
    a_latch_load: assert property (sup_link_wr_in && !ep_wr && !sr
        |=> sup_link_rdata_out == $past(sup_link_wdata_in)) else $error("latch load");
    a_ep_write: assert property (ep_wr && !sr |=> ep_link_wrote_out ##0
        sup_link_rdata_out == $past(ep_bus_in.wdata)) else $error("ep write");
    a_one_fetch: assert property (halted_out && fetch_one_in && !reset_run_in && !sr
        |=> !ep_hold_out) else $error("one fetch");
    a_reset_hold: assert property (reset_run_in && !sr
        |=> ep_reset_out [*5] ##1 !ep_reset_out) else $error("reset hold");
    a_pulse_cause: assert property (bp_pulse_out
        |-> !halted_out && $past(any_acc)) else $error("pulse cause");
    a_break_halt: assert property ($rose(break_out) |-> halted_out)
        else $error("break halt");
    a_sys_reset: assert property (sr |=> sup_reset_out && sup_link_rdata_out == 8'h00
        ##1 !sup_reset_out) else $error("sys reset");
    a_cfg_frozen: assert property (!halted_out |=> $stable(port_cfg_out))
        else $error("cfg frozen");
endmodule

// *** testbench/ebl_sup_model.sv ***
// Supervisor model: link latch, mapping and forced fetch
`timescale 1ns/1ps
module ebl_sup_model (
    // Clock, link latch, mapping and forced fetch
    input  logic              clk_in,
    input  logic [7:0]        rdata_in,
    input  logic              wrote_in,
    output logic              wr_out,
    output logic [7:0]        wdata_out,
    output ebl_pkg::ebl_map_e map_out,
    output logic              fetch_one_out
);
    // Low bytes and internal RAM saved, restored by firmware
    // User code within seven stack levels, no bus and/or
    logic [7:0] saved_q[$];
    initial begin
        wr_out = 1'b0;
        wdata_out = 8'h00;
        map_out = ebl_pkg::map_none;
        fetch_one_out = 1'b0;
    end
    always @(negedge clk_in) begin
        if (wrote_in === 1'b1) begin
            saved_q.push_back(rdata_in);
        end
    end
    task automatic write_link(logic [7:0] v);
        @(negedge clk_in);
        wr_out = 1'b1;
        wdata_out = v;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~v;
    endtask
    task automatic map_data();
        map_out = ebl_pkg::map_ext_data;
    endtask
    task automatic forced(logic [7:0] op);
        @(negedge clk_in);
        map_out = ebl_pkg::map_program;
        write_link(op);
        @(negedge clk_in);
        fetch_one_out = 1'b1;
        @(negedge clk_in);
        fetch_one_out = 1'b0;
    endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the break and link control
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] CALL_OP = 8'h14;
    localparam logic [7:0] RET_OP  = 8'h93;
    logic                 clk_in = 1'b0;
    logic                 nrst_in = 1'b0;
    logic                 sup_link_wr_in, ep_link_wrote_out, release_in, fetch_one_in;
    logic                 reset_run_in, system_reset_command_in, halted_out, break_out;
    logic                 sup_reset_out, link_oe_out, prog_ram_dis_out, data_ram_dis_out;
    logic                 ep_hold_out, ep_reset_out, key_press_in, bp_pulse_out, oe_seen;
    logic [7:0]           sup_link_wdata_in, sup_link_rdata_out, ep_rdata_out, d;
    logic [15:0]          pause_cycles_in, idle_cycles_in;
    logic [3:0]           port_cfg_in, port_cfg_out;
    logic [11:0]          a;
    ebl_pkg::ebl_map_e    link_map_in;
    ebl_pkg::ebl_mode_e   mode_in;
    ebl_pkg::ebl_ep_bus_s ep_bus_in;
    ebl_pkg::ebl_bp_cmd_s bp_cmd_in;
    int                   mismatches, cmp_count, cycles, n;
    ebl_sup_model sup (
        .clk_in        (clk_in),
        .rdata_in      (sup_link_rdata_out),
        .wrote_in      (ep_link_wrote_out),
        .wr_out        (sup_link_wr_in),
        .wdata_out     (sup_link_wdata_in),
        .map_out       (link_map_in),
        .fetch_one_out (fetch_one_in)
    );
    ebl_break_link dut (.*);
    always #50 clk_in = ~clk_in;
    task automatic chk(string s, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask
    function automatic logic [15:0] held(logic [15:0] v);
        return v + 16'h0001;
    endfunction
    task automatic acc(int k, logic [11:0] ad, logic [7:0] wd = 8'h00);
        @(negedge clk_in);
        ep_bus_in = '{k == 0, ad, k == 1, k == 2, ad, wd};
        #1 oe_seen = link_oe_out;
        @(negedge clk_in);
        ep_bus_in = '0;
    endtask
    task automatic pulse(ref logic s, input int w = 1);
        @(negedge clk_in);
        s = 1'b1;
        repeat (w) @(negedge clk_in);
        s = 1'b0;
    endtask
    task automatic bpc(logic set, logic dsp, logic [11:0] ad);
        @(negedge clk_in);
        bp_cmd_in = '{set, !set, dsp, ad};
        @(negedge clk_in);
        bp_cmd_in = '0;
    endtask
    task automatic go(ebl_pkg::ebl_mode_e m);
        mode_in = m;
        pulse(release_in);
    endtask
    task automatic stop();
        pulse(key_press_in, 6);
        repeat (5) @(negedge clk_in);
    endtask
    task automatic span(logic rst, output int c);
        c = 0;
        while ((rst ? ep_reset_out : ep_hold_out) === 1'b1 && c < 99) begin
            c++;
            @(negedge clk_in);
        end
    endtask
    task automatic done(string s);
        $display("test %s done", s);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        void'($urandom(5557));
        {release_in, reset_run_in, system_reset_command_in, key_press_in} = '0;
        ep_bus_in = '0;
        bp_cmd_in = '0;
        port_cfg_in = 4'h5;
        mode_in = ebl_pkg::run_breaks_enabled;
        pause_cycles_in = 16'($urandom % 6);
        idle_cycles_in = 16'($urandom % 4);
        a = 12'h100 + 12'($urandom % 3328);
        repeat (4) @(negedge clk_in);
        nrst_in = 1'b1;
        repeat (6) @(negedge clk_in);
        chk("cfg", port_cfg_out, 4'h5);
        d = 8'($urandom);
        sup.write_link(d);
        chk("latch", ep_rdata_out, d);
        sup.forced(CALL_OP);
        chk("hold", {ep_hold_out, prog_ram_dis_out}, 2'b01);
        acc(0, 12'($urandom));
        chk("fetch", {oe_seen, halted_out}, 2'b11);
        @(negedge clk_in);
        sup.map_data();
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            acc(2, 12'($urandom), d);
        end
        acc(1, 12'($urandom));
        chk("store", 16'(sup.saved_q.size()), 16'h0003);
        chk("stat", sup.saved_q[2], d);
        chk("rd_oe", {oe_seen, data_ram_dis_out}, 2'b11);
        sup.forced(RET_OP);
        chk("ret_op", {ep_hold_out, ep_rdata_out}, {1'b0, RET_OP});
        acc(0, 12'h000);
        chk("ret", halted_out, 1'b1);
        done("link");
        bpc(1'b1, 1'b0, a);
        bpc(1'b1, 1'b1, 12'hfff);
        bpc(1'b1, 1'b0, 12'h000);
        go(ebl_pkg::run_breaks_disabled);
        acc(0, a);
        chk("pulse", {bp_pulse_out, halted_out}, 2'b10);
        acc(0, a + 12'h001);
        chk("none", bp_pulse_out, 1'b0);
        acc(2, 12'hfff);
        chk("dpulse", bp_pulse_out, 1'b1);
        stop();
        chk("key", {halted_out, break_out}, 2'b11);
        go(ebl_pkg::run_breaks_enabled);
        acc(1, 12'hfff);
        chk("brk", {halted_out, break_out}, 2'b11);
        bpc(1'b0, 1'b1, 12'hfff);
        go(ebl_pkg::run_breaks_enabled);
        acc(1, 12'hfff);
        chk("clr", halted_out, 1'b0);
        acc(0, 12'h000);
        chk("low", halted_out, 1'b1);
        done("breakpoints");
        go(ebl_pkg::auto_break_mode);
        acc(0, a);
        span(1'b0, n);
        chk("pause", 16'(n), held(pause_cycles_in));
        port_cfg_in = 4'ha;
        repeat (6) @(negedge clk_in);
        chk("cfg_run", port_cfg_out, 4'h5);
        stop();
        chk("cfg_halt", port_cfg_out, 4'ha);
        go(ebl_pkg::single_step_mode);
        acc(0, a + 12'h002);
        chk("step", halted_out, 1'b1);
        go(ebl_pkg::auto_step_mode);
        acc(0, a + 12'h002);
        span(1'b0, n);
        chk("idle", 16'(n), held(idle_cycles_in));
        stop();
        chk("key_step", {halted_out, break_out}, 2'b11);
        done("modes");
        mode_in = ebl_pkg::run_breaks_enabled;
        pulse(reset_run_in);
        span(1'b1, n);
        chk("rst_run", 16'(n), ebl_pkg::EP_RST_CYCLES);
        pulse(system_reset_command_in);
        chk("sys", {sup_reset_out, sup_link_rdata_out}, 9'h100);
        repeat (10) @(negedge clk_in);
        acc(0, a);
        chk("flags", halted_out, 1'b0);
        done("resets");
        conclude();
    end
endmodule
bind ebl_break_link ebl_break_link_assertions u_chk (.*);
